//--- dbgx_pkg.sv
// Constants for the debug exception unit: register map, field layout, vectors.
// Assumes a 32-bit AXI4-Lite register bus and a core on the same clock.
// ----------------------------------------
// Functional notes
// ----------------------------------------
// Functional notes
// - Resume flag masks only instruction breakpoints; data, port and other exceptions still occur.
// - Clear resume flag on completion, except interrupt return or task-switching jump, call, interrupt.
// - Trap-class, hardware and software interrupt dispatch never sets the resume flag.
// - Data or port address hit with access type 1, 2 or 3 traps after completion.
// - A breakpointed write is committed before its debug trap is dispatched; here store_commit pulses in the same cycle as exc_valid.
// - Exact-match control bits are ignored; data matching is always exact.
// - Repeated port string instructions trap after the iteration touching the breakpointed location.
// - With general detect enabled, debug register access faults and sets the access status bit.
// - The general detect fault precedes the move, so the access is blocked.
// - Trap flag set at the start of an instruction gives a single-step trap after it.
// - No single-step trap after the instruction that sets the trap flag.
// - Trap flag is cleared before the single-step handler is entered.
// - Trap flag from an incoming task traps after its first instruction.
// - Privilege changes keep the trap flag; software interrupt and overflow trap clear it.
// - Single-step dispatches first, then a still pending external interrupt is serviced.
// - Task debug trap bit raises a debug trap on entry and sets task switch status.
// - The one-byte software breakpoint raises vector 3, not the debug vector.
// - Fast string breakpoints may be reported only at cache line boundaries.
// - Resume flag suppresses instruction breakpoint matches so restarts do not retrigger.
// - Debug conditions use vector 1; software breakpoints use vector 3.
package dbgx_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] DBGX_OFS_BPA0 = 8'h00;
	localparam logic [7:0] DBGX_OFS_CTRL = 8'h10;
	localparam logic [7:0] DBGX_OFS_STAT = 8'h14;
	localparam logic [7:0] DBGX_OFS_FLAGS = 8'h18;
	localparam logic [7:0] DBGX_OFS_LASTV = 8'h1c;
	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int DBGX_CTL_LEXACT = 8;
	localparam int DBGX_CTL_GEXACT = 9;
	localparam int DBGX_CTL_GDET = 13;
	localparam int DBGX_CTL_TYPE0 = 16;
	localparam int DBGX_CTL_LEN0 = 18;
	localparam int DBGX_CTL_STRIDE = 4;
	// ----------------------------------------
	// Status and flags fields
	// ----------------------------------------
	localparam int DBGX_ST_ACCESS = 13;
	localparam int DBGX_ST_STEP = 14;
	localparam int DBGX_ST_TASK = 15;
	localparam int DBGX_FL_TRAP = 8;
	localparam int DBGX_FL_RESUME = 16;
	localparam logic [31:0] DBGX_CTRL_RST = 32'h0000_0400;
	localparam logic [31:0] DBGX_STAT_RST = 32'hffff_0ff0;
	// ----------------------------------------
	// Access types, vectors, bus answers
	// ----------------------------------------
	localparam logic [1:0] DBGX_AT_EXEC = 2'h0;
	localparam logic [1:0] DBGX_AT_WRITE = 2'h1;
	localparam logic [1:0] DBGX_AT_PORT = 2'h2;
	localparam logic [1:0] DBGX_AT_RDWR = 2'h3;
	localparam logic [7:0] DBGX_VEC_DEBUG = 8'h01;
	localparam logic [7:0] DBGX_VEC_BREAK = 8'h03;
	localparam logic [1:0] DBGX_RESP_OKAY = 2'h0;
	localparam logic [1:0] DBGX_RESP_SLVERR = 2'h2;
endpackage

//--- dbgx_unit.sv
// Debug exception detection and dispatch for one core, with AXI4-Lite registers.
// Assumes core event inputs are on aclk, one instruction retires per cycle at most.
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module dbgx_unit import dbgx_pkg::*; #(
	parameter int NBP = 4,
	parameter bit FAST_COARSE = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_pc,
	input wire logic dreg_access,
	input wire logic mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_len,
	input wire logic mem_write,
	input wire logic mem_port,
	input wire logic iter_done,
	input wire logic fast_string,
	input wire logic line_end,
	input wire logic retire_valid,
	input wire logic retire_iret,
	input wire logic retire_task_switch,
	input wire logic retire_swint,
	input wire logic retire_overflow,
	input wire logic retire_int3,
	input wire logic retire_load_flags,
	input wire logic retire_new_trap,
	input wire logic retire_new_resume,
	input wire logic new_task_debug,
	input wire logic fault_dispatch,
	input wire logic ext_irq,
	output logic store_commit,
	output logic dreg_grant,
	output logic exc_valid,
	output logic [7:0] exc_vector,
	output logic exc_fault,
	output logic irq_service,
	output logic resume_flag,
	output logic trap_flag
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [31:0] len_mask(input logic [1:0] len);
		case (len)
			2'h1: len_mask = 32'hffff_fffe;
			2'h3: len_mask = 32'hffff_fffc;
			2'h2: len_mask = 32'hffff_fff8;
			default: len_mask = 32'hffff_ffff;
		endcase
	endfunction
	// Exact overlap of two aligned regions
	function automatic logic addr_hit(input logic [31:0] a, input logic [1:0] al,
		input logic [31:0] b, input logic [1:0] bl);
		logic [31:0] m;
		m = len_mask(al) & len_mask(bl);
		addr_hit = (a & m) == (b & m);
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] bpa_q [NBP];
	logic [31:0] ctrl_q;
	logic [31:0] stat_q;
	logic [7:0] lastv_q;
	logic [NBP-1:0] dhit_q;
	logic bp_pend_q;
	logic step_disp_q;
	logic [7:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wdo_q;
	logic [NBP-1:0] ihit, dhit_now, dpend;
	logic ifault, gdfault, report, step_trap, ts_trap, dbg_trap, int3_go;
	logic [31:0] stat_set;
	always_comb begin
		for (int n = 0; n < NBP; n++) begin
			logic en;
			logic [1:0] at;
			logic [1:0] ln;
			logic kind_ok;
			kind_ok = 1'b0;
			en = ctrl_q[2*n] | ctrl_q[2*n+1];
			at = ctrl_q[DBGX_CTL_TYPE0 + DBGX_CTL_STRIDE*n +: 2];
			ln = ctrl_q[DBGX_CTL_LEN0 + DBGX_CTL_STRIDE*n +: 2];
			ihit[n] = en && at == DBGX_AT_EXEC && fetch_pc == bpa_q[n];
			case (at)
				DBGX_AT_WRITE: kind_ok = mem_write && !mem_port;
				DBGX_AT_PORT: kind_ok = mem_port;
				DBGX_AT_RDWR: kind_ok = !mem_port;
				default: kind_ok = 1'b0;
			endcase
			// Exact-match bits never looked at here
			dhit_now[n] = mem_valid && en && kind_ok && addr_hit(mem_addr, mem_len, bpa_q[n], ln);
		end
	end
	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	assign ifault = fetch_valid && !resume_flag && (|ihit);
	assign gdfault = dreg_access && ctrl_q[DBGX_CTL_GDET];
	// Coarse fast-string reporting trades precision for a simpler string path
	assign report = retire_valid || (iter_done && (!(FAST_COARSE && fast_string) || line_end));
	assign dpend = dhit_q | dhit_now;
	assign step_trap = retire_valid && trap_flag;
	assign ts_trap = retire_valid && retire_task_switch && new_task_debug;
	assign dbg_trap = report && ((|dpend) || step_trap || ts_trap);
	assign int3_go = (retire_valid && retire_int3) || bp_pend_q;
	always_comb begin
		stat_set = 32'h0;
		// Access bit recorded even when a coinciding trap wins dispatch
		stat_set[DBGX_ST_ACCESS] = gdfault;
		if (dbg_trap) begin
			stat_set[NBP-1:0] = dpend;
			stat_set[DBGX_ST_STEP] = step_trap;
			stat_set[DBGX_ST_TASK] = ts_trap;
		end else if (ifault || gdfault) begin
			stat_set[NBP-1:0] = fetch_valid ? ihit & {NBP{!resume_flag}} : '0;
		end
	end
	// Hits collected across iterations until reported
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dhit_q <= '0;
		end else if (report) begin
			dhit_q <= '0;
		end else begin
			dhit_q <= dpend;
		end
	end
	// ----------------------------------------
	// Dispatch
	// ----------------------------------------
	// Traps of the finished instruction beat a fault seen at fetch; the core refetches
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exc_valid <= 1'b0;
			exc_vector <= 8'h0;
			exc_fault <= 1'b0;
			bp_pend_q <= 1'b0;
			step_disp_q <= 1'b0;
			lastv_q <= 8'h0;
		end else begin
			exc_valid <= dbg_trap || int3_go || ifault || gdfault;
			step_disp_q <= dbg_trap && step_trap;
			bp_pend_q <= dbg_trap && int3_go;
			exc_fault <= !dbg_trap && !int3_go && (ifault || gdfault);
			if (dbg_trap) begin
				exc_vector <= DBGX_VEC_DEBUG;
				lastv_q <= DBGX_VEC_DEBUG;
			end else if (int3_go) begin
				exc_vector <= DBGX_VEC_BREAK;
				lastv_q <= DBGX_VEC_BREAK;
			end else if (ifault || gdfault) begin
				exc_vector <= DBGX_VEC_DEBUG;
				lastv_q <= DBGX_VEC_DEBUG;
			end
		end
	end
	// Writes commit one edge after the retire cycle, on the same edge the trap goes out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			store_commit <= 1'b0;
			dreg_grant <= 1'b0;
			irq_service <= 1'b0;
		end else begin
			store_commit <= retire_valid && mem_valid && mem_write;
			dreg_grant <= dreg_access && !gdfault;
			irq_service <= step_disp_q && ext_irq;
		end
	end
	// ----------------------------------------
	// Flags
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trap_flag <= 1'b0;
		end else if (dbg_trap && step_trap) begin
			trap_flag <= 1'b0;
		end else if (retire_valid && (retire_swint || retire_overflow)) begin
			trap_flag <= 1'b0;
		end else if (retire_valid && retire_load_flags) begin
			trap_flag <= retire_new_trap;
		end else if (wdo_q && waddr_q == DBGX_OFS_FLAGS && wstrb_q[DBGX_FL_TRAP/8]) begin
			trap_flag <= wdata_q[DBGX_FL_TRAP];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			resume_flag <= 1'b0;
		end else if (fault_dispatch || (gdfault && !dbg_trap && !int3_go)) begin
			resume_flag <= 1'b1;
		end else if (retire_valid) begin
			if (retire_iret || retire_task_switch) begin
				resume_flag <= retire_new_resume;
			end else begin
				resume_flag <= 1'b0;
			end
		end else if (wdo_q && waddr_q == DBGX_OFS_FLAGS && wstrb_q[DBGX_FL_RESUME/8]) begin
			resume_flag <= wdata_q[DBGX_FL_RESUME];
		end
	end
	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic wmap;
	assign wmap = waddr_q < DBGX_OFS_LASTV;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DBGX_RESP_OKAY;
			wdo_q <= 1'b0;
			waddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			wdo_q <= 1'b0;
			if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid && !wdo_q) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				waddr_q <= {s_axi_awaddr[7:2], 2'h0};
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				wdo_q <= 1'b1;
			end
			if (wdo_q) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wmap ? DBGX_RESP_OKAY : DBGX_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int n = 0; n < NBP; n++) begin
				bpa_q[n] <= 32'h0;
			end
			ctrl_q <= DBGX_CTRL_RST;
		end else if (wdo_q) begin
			for (int n = 0; n < NBP; n++) begin
				if (waddr_q == DBGX_OFS_BPA0 + 8'(4*n)) begin
					bpa_q[n] <= merge(bpa_q[n], wdata_q, wstrb_q);
				end
			end
			if (waddr_q == DBGX_OFS_CTRL) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			end
		end
	end
	// Hardware set wins over a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= DBGX_STAT_RST;
		end else if (wdo_q && waddr_q == DBGX_OFS_STAT) begin
			stat_q <= merge(stat_q, wdata_q, wstrb_q) | stat_set;
		end else begin
			stat_q <= stat_q | stat_set;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= DBGX_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= DBGX_RESP_OKAY;
				s_axi_rdata <= 32'h0;
				case ({s_axi_araddr[7:2], 2'h0})
					DBGX_OFS_CTRL: s_axi_rdata <= ctrl_q;
					DBGX_OFS_STAT: s_axi_rdata <= stat_q;
					DBGX_OFS_FLAGS: s_axi_rdata <= 32'(trap_flag) << DBGX_FL_TRAP | 32'(resume_flag) << DBGX_FL_RESUME;
					DBGX_OFS_LASTV: s_axi_rdata <= {24'h0, lastv_q};
					default: begin
						if (s_axi_araddr < DBGX_OFS_CTRL) begin
							s_axi_rdata <= bpa_q[s_axi_araddr[3:2]];
						end else begin
							s_axi_rresp <= DBGX_RESP_SLVERR;
						end
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	resume_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fetch_valid && resume_flag && !gdfault && !dbg_trap && !int3_go |=> !exc_valid)
		else $error("Instruction breakpoint reported with resume flag set");
	resume_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire_valid && !retire_iret && !retire_task_switch && !fault_dispatch && !gdfault |=> !resume_flag)
		else $error("Resume flag survived a plain completion");
	trap_no_resume_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!resume_flag && !fault_dispatch && !gdfault && !retire_valid && !wdo_q |=> !resume_flag)
		else $error("Resume flag set without a fault dispatch");
	data_trap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire_valid && (|dhit_now) |=> exc_valid && exc_vector == DBGX_VEC_DEBUG && !exc_fault)
		else $error("Data breakpoint did not trap");
	commit_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire_valid && mem_valid && mem_write |=> store_commit)
		else $error("Store not committed with its trap");
	gd_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		gdfault |=> stat_q[DBGX_ST_ACCESS] && !dreg_grant)
		else $error("General detect missing or access granted");
	step_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire_valid && trap_flag |=> !trap_flag ##1 !trap_flag || $past(retire_valid))
		else $error("Trap flag not cleared on single step");
	task_trap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ts_trap |=> exc_valid && stat_q[DBGX_ST_TASK])
		else $error("Task debug trap not raised");
	break_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire_valid && retire_int3 && !dbg_trap |=> exc_valid && exc_vector == DBGX_VEC_BREAK)
		else $error("Software breakpoint vector wrong");
	irq_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
		step_disp_q && ext_irq |=> irq_service)
		else $error("Pending interrupt not serviced after single step");
	step_cov: cover property (@(posedge aclk) disable iff (!aresetn) step_trap ##1 exc_valid);
	gd_cov: cover property (@(posedge aclk) disable iff (!aresetn) gdfault ##1 exc_fault);
	multi_cov: cover property (@(posedge aclk) disable iff (!aresetn) step_trap && (|dpend) && retire_valid);
	int3_cov: cover property (@(posedge aclk) disable iff (!aresetn) dbg_trap && int3_go ##2 exc_vector == DBGX_VEC_BREAK);
endmodule

//--- tb_top.sv
// Self-checking bench for the debug exception unit: registers, traps, faults, vectors.
// Assumes dbgx_pkg and dbgx_unit are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module tb_top import dbgx_pkg::*; ;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [13:0] E_RET = 14'h0200, E_DREG = 14'h0400, E_FETCH = 14'h0800, E_MEM = 14'h1000;
	localparam logic [13:0] E_ITER = 14'h2000, Q_IRET = 14'h0100, Q_TS = 14'h0080, Q_SWI = 14'h0040;
	localparam logic [13:0] Q_OVF = 14'h0020, Q_INT3 = 14'h0010, Q_LDF = 14'h0008, Q_NTRAP = 14'h0004;
	localparam logic [13:0] Q_NRES = 14'h0002, Q_NTD = 14'h0001;
	logic aclk = 1'h0, aresetn = 1'h0, ext_irq = 1'h0, mem_write = 1'h0, mem_port = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, fetch_pc = 32'h0, mem_addr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] mem_len = 2'h0;
	logic [13:0] ev_q = 14'h0;
	logic fetch_valid, dreg_access, mem_valid, iter_done, retire_valid, retire_iret, retire_task_switch;
	logic retire_swint, retire_overflow, retire_int3, retire_load_flags, retire_new_trap, retire_new_resume;
	logic new_task_debug, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic store_commit, dreg_grant, exc_valid, exc_fault, irq_service, resume_flag, trap_flag;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] exc_vector;
	int n_fail = 0, samples_checked = 0, sc_cnt = 0, gr_cnt = 0;
	// Fast string and fault inputs start idle; single scenarios pulse them
	logic fast_string = 1'h0, line_end = 1'h0, fault_dispatch = 1'h0;
	assign {iter_done, mem_valid, fetch_valid, dreg_access, retire_valid, retire_iret, retire_task_switch} = ev_q[13:7];
	assign {retire_swint, retire_overflow, retire_int3, retire_load_flags} = ev_q[6:3];
	assign {retire_new_trap, retire_new_resume, new_task_debug} = ev_q[2:0];
	dbgx_unit u_dbgx_unit (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_valid,
		.fetch_pc, .dreg_access, .mem_valid, .mem_addr, .mem_len, .mem_write, .mem_port, .iter_done, .fast_string,
		.line_end, .retire_valid, .retire_iret, .retire_task_switch, .retire_swint, .retire_overflow, .retire_int3,
		.retire_load_flags, .retire_new_trap, .retire_new_resume, .new_task_debug, .fault_dispatch, .ext_irq,
		.store_commit, .dreg_grant, .exc_valid, .exc_vector, .exc_fault, .irq_service, .resume_flag, .trap_flag);
	initial begin
		forever #5 aclk = ~aclk;
	end
	// Store commit and grant pulses are counted so ordering can be judged after the fact
	always @(posedge aclk) begin
		if (store_commit === 1'h1) sc_cnt <= sc_cnt + 1;
		if (dreg_grant === 1'h1) gr_cnt <= gr_cnt + 1;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bail();
		chk(32'h0, 32'h1);
		final_report();
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 20; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) break;
		end
		s_axi_bready <= 1'h0;
		if (n == 20) bail();
		chk(s_axi_bresp, er);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 20; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) break;
		end
		s_axi_rready <= 1'h0;
		if (n == 20) bail();
		d = s_axi_rdata;
		chk(s_axi_rresp, er);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] d;
		axi_rd(a, d, DBGX_RESP_OKAY);
		chk(d & m, exp);
	endtask
	task automatic step(input logic [13:0] v);
		@(posedge aclk);
		ev_q <= v;
		@(posedge aclk);
		ev_q <= 14'h0;
	endtask
	task automatic wait_exc(input logic [7:0] vec, input logic flt);
		int n;
		for (n = 0; n < 4; n++) begin
			@(posedge aclk);
			if (exc_valid === 1'h1) break;
		end
		if (n == 4) bail();
		chk(exc_vector, vec);
		chk(exc_fault, flt);
	endtask
	task automatic no_exc();
		int n;
		logic seen;
		seen = 1'h0;
		for (n = 0; n < 4; n++) begin
			@(posedge aclk);
			seen = seen | exc_valid;
		end
		chk(seen, 1'h0);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		rdc(DBGX_OFS_CTRL, 32'hffffffff, DBGX_CTRL_RST);
		rdc(DBGX_OFS_STAT, 32'hffffffff, DBGX_STAT_RST);
		axi_rd(8'h20, d, DBGX_RESP_SLVERR);
		chk(d, 32'h0);
		axi_wr(DBGX_OFS_LASTV, 32'h3, DBGX_RESP_SLVERR);
		rdc(DBGX_OFS_LASTV, 32'hff, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_step();
		int n;
		axi_wr(DBGX_OFS_STAT, 32'h0, DBGX_RESP_OKAY);
		axi_wr(DBGX_OFS_FLAGS, 32'h100, DBGX_RESP_OKAY);
		ext_irq <= 1'h1;
		step(E_RET);
		wait_exc(DBGX_VEC_DEBUG, 1'h0);
		chk(trap_flag, 1'h0);
		for (n = 0; n < 3 && irq_service !== 1'h1; n++) @(posedge aclk);
		chk(irq_service, 1'h1);
		ext_irq <= 1'h0;
		chk(resume_flag, 1'h0);
		rdc(DBGX_OFS_STAT, 32'h4000, 32'h4000);
		for (n = 0; n < 2; n++) begin
			step(E_RET | Q_NTRAP | Q_LDF | (n == 1 ? Q_TS : 14'h0));
			no_exc();
			chk(trap_flag, 1'h1);
			step(E_RET);
			wait_exc(DBGX_VEC_DEBUG, 1'h0);
		end
		for (n = 0; n < 2; n++) begin
			axi_wr(DBGX_OFS_FLAGS, 32'h0, DBGX_RESP_OKAY);
			// A flags load in the same instruction must lose to the clear
			step(E_RET | Q_LDF | Q_NTRAP | (n == 1 ? Q_OVF : Q_SWI));
			repeat (4) @(posedge aclk);
			chk(trap_flag, 1'h0);
			chk(resume_flag, 1'h0);
		end
		$display("test single step done");
	endtask
	task automatic t_gd();
		int g0;
		g0 = gr_cnt;
		step(E_DREG);
		no_exc();
		chk(gr_cnt - g0, 1);
		axi_wr(DBGX_OFS_STAT, 32'h0, DBGX_RESP_OKAY);
		axi_wr(DBGX_OFS_CTRL, 32'h2000, DBGX_RESP_OKAY);
		g0 = gr_cnt;
		step(E_DREG);
		wait_exc(DBGX_VEC_DEBUG, 1'h1);
		repeat (2) @(posedge aclk);
		chk(gr_cnt - g0, 0);
		rdc(DBGX_OFS_STAT, 32'h2000, 32'h2000);
		axi_wr(DBGX_OFS_CTRL, DBGX_CTRL_RST, DBGX_RESP_OKAY);
		$display("test general detect done");
	endtask
	task automatic t_data();
		int i, c0;
		axi_wr(DBGX_OFS_BPA0, 32'h1000, DBGX_RESP_OKAY);
		mem_addr <= 32'h1000;
		for (i = 1; i < 4; i++) begin
			// Exact-match bits set on purpose: matching must not depend on them
			axi_wr(DBGX_OFS_CTRL, 32'h301 | (32'(i) << DBGX_CTL_TYPE0), DBGX_RESP_OKAY);
			axi_wr(DBGX_OFS_FLAGS, 32'h10000, DBGX_RESP_OKAY);
			mem_write <= (i == 1);
			mem_port <= (i == 2);
			c0 = sc_cnt;
			step(E_RET | E_MEM);
			wait_exc(DBGX_VEC_DEBUG, 1'h0);
			if (i == 1) chk((sc_cnt != c0) || store_commit, 1);
		end
		mem_addr <= 32'h1001;
		step(E_RET | E_MEM);
		no_exc();
		axi_wr(DBGX_OFS_CTRL, 32'h1 | (32'(DBGX_AT_WRITE) << DBGX_CTL_TYPE0), DBGX_RESP_OKAY);
		mem_addr <= 32'h1000;
		mem_write <= 1'h1;
		mem_port <= 1'h0;
		step(E_MEM | E_ITER);
		wait_exc(DBGX_VEC_DEBUG, 1'h0);
		fast_string <= 1'h1;
		step(E_MEM | E_ITER);
		no_exc();
		line_end <= 1'h1;
		step(E_ITER);
		wait_exc(DBGX_VEC_DEBUG, 1'h0);
		fast_string <= 1'h0;
		line_end <= 1'h0;
		$display("test data breakpoint done");
	endtask
	task automatic t_ibp();
		int i;
		axi_wr(DBGX_OFS_BPA0, 32'h2000, DBGX_RESP_OKAY);
		axi_wr(DBGX_OFS_CTRL, 32'h1, DBGX_RESP_OKAY);
		fetch_pc <= 32'h2000;
		for (i = 0; i < 2; i++) begin
			axi_wr(DBGX_OFS_FLAGS, 32'h10000, DBGX_RESP_OKAY);
			step(E_FETCH);
			no_exc();
			step(E_RET | Q_NRES | (i == 1 ? Q_TS : Q_IRET));
			@(posedge aclk);
			chk(resume_flag, 1'h1);
			step(E_RET);
			@(posedge aclk);
			chk(resume_flag, 1'h0);
		end
		step(E_FETCH);
		wait_exc(DBGX_VEC_DEBUG, 1'h1);
		axi_wr(DBGX_OFS_CTRL, DBGX_CTRL_RST, DBGX_RESP_OKAY);
		$display("test instruction breakpoint done");
	endtask
	task automatic t_misc();
		fault_dispatch <= 1'h1;
		@(posedge aclk);
		fault_dispatch <= 1'h0;
		@(posedge aclk);
		chk(resume_flag, 1'h1);
		axi_wr(DBGX_OFS_FLAGS, 32'h0, DBGX_RESP_OKAY);
		step(E_RET | Q_INT3);
		wait_exc(DBGX_VEC_BREAK, 1'h0);
		@(posedge aclk);
		chk(resume_flag, 1'h0);
		rdc(DBGX_OFS_LASTV, 32'hff, 32'h3);
		axi_wr(DBGX_OFS_STAT, 32'h0, DBGX_RESP_OKAY);
		axi_wr(DBGX_OFS_FLAGS, 32'h100, DBGX_RESP_OKAY);
		step(E_RET | Q_TS | Q_NTD);
		wait_exc(DBGX_VEC_DEBUG, 1'h0);
		rdc(DBGX_OFS_STAT, 32'hc000, 32'hc000);
		$display("test vectors and task switch done");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_step();
		t_gd();
		t_data();
		t_ibp();
		t_misc();
		final_report();
	end
endmodule
